// ---- dv/cascadable_timer_pair_tb_top.sv ----
// Self-checking bench: APB traffic, pin stimulus, predicted counts.
// Assumes the timer pair, its package and the pin source compile first.
`timescale 1ns/10ps
`default_nettype none
`include "ctp_cfg.svh"

`define CTPTB_CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            n_mismatch++; \
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end

module cascadable_timer_pair_tb_top;
    // ------------------------------------------------------------------
    // stimulus, responses and bookkeeping
    // ------------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic ck_lo, ck_hi, gt_lo, gt_hi;
    wire logic irq;
    wire logic [2:0] irq_priority;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'h1C986CCD;
    int n;
    int p;
    logic [31:0] rv;
    logic [31:0] c1;
    logic ev;
    logic [31:0] rst_tab [0:8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF,
                                   32'hFFFF, 32'h0, 32'h0, 32'h44};

    ctp_timer_pair i_ctp_timer_pair (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_clk_lo_pin(ck_lo), .ext_clk_hi_pin(ck_hi),
        .gate_lo_pin(gt_lo), .gate_hi_pin(gt_hi), .irq(irq),
        .irq_priority(irq_priority));

    ctp_pin_source i_ctp_pin_source (
        .pclk(pclk), .ext_clk_lo_pin(ck_lo), .ext_clk_hi_pin(ck_hi),
        .gate_lo_pin(gt_lo), .gate_hi_pin(gt_hi));

    // 20 MHz clock
    always #25 pclk = ~pclk;

    // ------------------------------------------------------------------
    // bus tasks and helpers
    // ------------------------------------------------------------------
    task automatic end_of_test;
        if (n_mismatch == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // request held until pready is seen high at a rising edge; answer taken there
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic err);
        logic rdy;
        int k;
        rdy = 1'b0;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        while (rdy !== 1'b1 && k < 100) begin
            @(posedge pclk);
            rdy = pready;
            k++;
        end
        r = prdata;
        err = pslverr;
        if (rdy !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, $random(seed), rv, ev);
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        `CTPTB_CHK(rv, e)
    endtask : rchk

    function automatic logic near(input logic [31:0] g, input int e,
                                  input int t);
        return (g >= e - t) && (g <= e + t);
    endfunction : near

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 9; i++) rchk(8'(i * 4), rst_tab[i]);
        rd(8'h24);
        `CTPTB_CHK({ev, rv}, 33'h100000000)
        rd(8'h02);
        `CTPTB_CHK(ev, 1'b1)
        wr(`CTP_ADDR_CTRL_HI, 32'hFFFFFFFF);
        rchk(`CTP_ADDR_CTRL_HI, 32'hA072);
        wr(`CTP_ADDR_CTRL_HI, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'hFFFFFFFF);
        rchk(`CTP_ADDR_CTRL_LO, 32'hA07A);
        wr(`CTP_ADDR_CTRL_LO, 32'h0);
        wr(`CTP_ADDR_CNT_HI, 32'h0);
        // each prescale code against elapsed pclk cycles
        for (int s = 0; s < 4; s++) begin
            p = (s == 0) ? 1 : (s == 1) ? 8 : (s == 2) ? 64 : 256;
            wr(`CTP_ADDR_CNT_LO, 32'h0);
            wr(`CTP_ADDR_CTRL_LO, 32'h8000 | (s << 4));
            repeat (p * 5) @(posedge pclk);
            wr(`CTP_ADDR_CTRL_LO, 32'h0);
            rd(`CTP_ADDR_CNT_LO);
            `CTPTB_CHK(near(rv, (p * 5 + 3) / p, 2), 1'b1)
            rchk(`CTP_ADDR_CNT_HI, 32'h0);
        end
        // period wrap, sticky flag, mask and priority gating
        p = 2 + ($unsigned($random(seed)) % 6);
        wr(`CTP_ADDR_PER_LO, p);
        wr(`CTP_ADDR_CNT_LO, 32'h0);
        wr(`CTP_ADDR_IRQ_MASK, 32'h1);
        wr(`CTP_ADDR_CTRL_LO, 32'h8000);
        for (int i = 0; i < 6; i++) begin
            rd(`CTP_ADDR_CNT_LO);
            `CTPTB_CHK(rv <= p, 1'b1)
        end
        // outputs looked at mid-cycle, bus resumes after the next rise
        @(negedge pclk);
        `CTPTB_CHK({irq, irq_priority}, 4'hC)
        @(posedge pclk);
        wr(`CTP_ADDR_IRQ_PRIO, 32'h40);
        @(negedge pclk);
        `CTPTB_CHK(irq, 1'b0)
        @(posedge pclk);
        wr(`CTP_ADDR_CTRL_LO, 32'h0);
        wr(`CTP_ADDR_IRQ_PRIO, 32'h44);
        wr(`CTP_ADDR_IRQ_MASK, 32'h0);
        @(negedge pclk);
        `CTPTB_CHK(irq, 1'b0)
        @(posedge pclk);
        rchk(`CTP_ADDR_IRQ_STAT, 32'h1);
        wr(`CTP_ADDR_IRQ_STAT, 32'h1);
        rchk(`CTP_ADDR_IRQ_STAT, 32'h0);
        // paired: carry into the high word, upper control ignored
        wr(`CTP_ADDR_CTRL_LO, 32'h0008);
        wr(`CTP_ADDR_CTRL_HI, 32'h8000);
        wr(`CTP_ADDR_CNT_LO, 32'hFFFE);
        wr(`CTP_ADDR_CNT_HI, 32'h0);
        wr(`CTP_ADDR_PER_LO, 32'h0010);
        wr(`CTP_ADDR_PER_HI, 32'h0001);
        wr(`CTP_ADDR_IRQ_MASK, 32'h2);
        wr(`CTP_ADDR_CTRL_LO, 32'h8008);
        repeat (2) @(posedge pclk);
        wr(`CTP_ADDR_CTRL_LO, 32'h0008);
        rchk(`CTP_ADDR_CNT_HI, 32'h1);
        rd(`CTP_ADDR_CNT_LO);
        `CTPTB_CHK(rv <= 8, 1'b1)
        rchk(`CTP_ADDR_IRQ_STAT, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'h8008);
        repeat (40) @(posedge pclk);
        wr(`CTP_ADDR_CTRL_LO, 32'h0008);
        rchk(`CTP_ADDR_IRQ_STAT, 32'h2);
        @(negedge pclk);
        `CTPTB_CHK({irq, irq_priority}, 4'hC)
        @(posedge pclk);
        wr(`CTP_ADDR_IRQ_PRIO, 32'h04);
        @(negedge pclk);
        `CTPTB_CHK(irq, 1'b0)
        @(posedge pclk);
        wr(`CTP_ADDR_IRQ_PRIO, 32'h44);
        wr(`CTP_ADDR_IRQ_STAT, 32'h3);
        wr(`CTP_ADDR_CTRL_HI, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'h0);
        // counter mode: each timer on its own pin, then paired
        n = 3 + ($unsigned($random(seed)) % 8);
        wr(`CTP_ADDR_CNT_LO, 32'h0);
        wr(`CTP_ADDR_CNT_HI, 32'h0);
        wr(`CTP_ADDR_PER_LO, 32'hFFFF);
        wr(`CTP_ADDR_PER_HI, 32'hFFFF);
        wr(`CTP_ADDR_CTRL_LO, 32'h8002);
        i_ctp_pin_source.pulses(1'b0, n);
        repeat (6) @(posedge pclk);
        rchk(`CTP_ADDR_CNT_LO, n);
        wr(`CTP_ADDR_CTRL_HI, 32'h8002);
        i_ctp_pin_source.pulses(1'b1, n + 1);
        repeat (6) @(posedge pclk);
        rchk(`CTP_ADDR_CNT_HI, n + 1);
        rchk(`CTP_ADDR_CNT_LO, n);
        wr(`CTP_ADDR_CTRL_HI, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'h0008);
        wr(`CTP_ADDR_CNT_LO, 32'hFFFF);
        wr(`CTP_ADDR_CNT_HI, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'h800A);
        i_ctp_pin_source.pulses(1'b0, 2);
        repeat (6) @(posedge pclk);
        rchk(`CTP_ADDR_CNT_HI, 32'h1);
        rchk(`CTP_ADDR_CNT_LO, 32'h1);
        // gated mode: no count while closed, about 30 cycles while open
        wr(`CTP_ADDR_CTRL_LO, 32'h0);
        wr(`CTP_ADDR_CNT_LO, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'h8040);
        repeat (20) @(posedge pclk);
        rchk(`CTP_ADDR_CNT_LO, 32'h0);
        i_ctp_pin_source.gate_for(1'b0, 30);
        repeat (4) @(posedge pclk);
        wr(`CTP_ADDR_CTRL_LO, 32'h0);
        rd(`CTP_ADDR_CNT_LO);
        `CTPTB_CHK(near(rv, 30, 2), 1'b1)
        // freeze: clock enable low stops the count
        wr(`CTP_ADDR_CNT_LO, 32'h0);
        wr(`CTP_ADDR_CTRL_LO, 32'h8000);
        rd(`CTP_ADDR_CNT_LO);
        c1 = rv;
        clk_en <= 1'b0;
        repeat (20) @(posedge pclk);
        clk_en <= 1'b1;
        @(posedge pclk);
        rd(`CTP_ADDR_CNT_LO);
        `CTPTB_CHK((rv - c1) < 10, 1'b1)
        end_of_test();
    end

    // hang guard, far beyond the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
endmodule : cascadable_timer_pair_tb_top
`default_nettype wire

// ---- dv/ctp_pin_source.sv ----
// Far-side model for the timer pair: external clock pulses and gates.
// Assumes its tasks are called just after a rising pclk edge.
`timescale 1ns/10ps
`default_nettype none

module ctp_pin_source (
    // clock
    input wire logic pclk,
    // pins toward the timer pair
    output var logic ext_clk_lo_pin,
    output var logic ext_clk_hi_pin,
    output var logic gate_lo_pin,
    output var logic gate_hi_pin
);
    // ------------------------------------------------------------------
    // idle levels and stimulus tasks
    // ------------------------------------------------------------------
    // pins rest low between bursts
    initial begin
        ext_clk_lo_pin = 1'b0;
        ext_clk_hi_pin = 1'b0;
        gate_lo_pin = 1'b0;
        gate_hi_pin = 1'b0;
    end

    // four cycles high, four low: well above the two-flop sync window
    task automatic pulses(input logic hi, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            ext_clk_lo_pin <= !hi;
            ext_clk_hi_pin <= hi;
            repeat (4) @(posedge pclk);
            ext_clk_lo_pin <= 1'b0;
            ext_clk_hi_pin <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask : pulses

    // gate held open for n cycles, then closed again
    task automatic gate_for(input logic hi, input int n);
        @(posedge pclk);
        gate_lo_pin <= !hi;
        gate_hi_pin <= hi;
        repeat (n) @(posedge pclk);
        gate_lo_pin <= 1'b0;
        gate_hi_pin <= 1'b0;
    endtask : gate_for
endmodule : ctp_pin_source
`default_nettype wire

// ---- verilog/ctp_cfg.svh ----
// Register offsets, field positions, reset values and prescale terminal
// counts for the cascadable timer pair.
// Assumes byte addressing on an APB bus with 32-bit data words.
`ifndef CTP_CFG_SVH
`define CTP_CFG_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------
`define CTP_ADDR_CTRL_LO 8'h00
`define CTP_ADDR_CTRL_HI 8'h04
`define CTP_ADDR_CNT_LO 8'h08
`define CTP_ADDR_CNT_HI 8'h0C
`define CTP_ADDR_PER_LO 8'h10
`define CTP_ADDR_PER_HI 8'h14
`define CTP_ADDR_IRQ_STAT 8'h18
`define CTP_ADDR_IRQ_MASK 8'h1C
`define CTP_ADDR_IRQ_PRIO 8'h20

// ----------------------------------------------------------------------
// timer_control_reg fields
// ----------------------------------------------------------------------
`define CTP_CTRL_CS 1
`define CTP_CTRL_PAIR 3
`define CTP_CTRL_PS_LSB 4
`define CTP_CTRL_PS_MSB 5
`define CTP_CTRL_GATE 6
`define CTP_CTRL_SIDL 13
`define CTP_CTRL_RUN 15
`define CTP_CTRL_LO_MASK 16'hA07A
`define CTP_CTRL_HI_MASK 16'hA072

// ----------------------------------------------------------------------
// interrupt fields and reset values
// ----------------------------------------------------------------------
`define CTP_IRQ_LO 0
`define CTP_IRQ_HI 1
`define CTP_PRIO_LO_LSB 0
`define CTP_PRIO_HI_LSB 4
`define CTP_CTRL_RST 16'h0000
`define CTP_PER_RST 16'hFFFF
`define CTP_PRIO_RST 3'h4

// ----------------------------------------------------------------------
// prescaler terminal counts (ratio minus one)
// ----------------------------------------------------------------------
`define CTP_PS_TERM_1 8'h00
`define CTP_PS_TERM_8 8'h07
`define CTP_PS_TERM_64 8'h3F
`define CTP_PS_TERM_256 8'hFF

`endif

// ---- verilog/ctp_pkg.sv ----
// Types shared by the cascadable timer pair.
// Assumes the constants header provides all numeric values other than the mode codes.
package ctp_pkg;

    // ------------------------------------------------------------------
    // operating modes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CTP_MODE_TIMER = 3'b001,
        CTP_MODE_GATED = 3'b010,
        CTP_MODE_COUNTER = 3'b100
    } ctp_mode_type;

endpackage : ctp_pkg

// ---- verilog/ctp_timer_pair.sv ----
// Two 16-bit timers (lower and upper word) behind an APB slave, joinable
// into one 32-bit timer, with sticky interrupt flags and a mask.
// Assumes pclk is the instruction clock; pins are asynchronous to it.
`timescale 1ns/10ps
`default_nettype none
`include "ctp_cfg.svh"

module ctp_timer_pair
    import ctp_pkg::*;
(
    // clock, reset, freeze
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pins
    input wire logic ext_clk_lo_pin,
    input wire logic ext_clk_hi_pin,
    input wire logic gate_lo_pin,
    input wire logic gate_hi_pin,
    // interrupt
    output logic irq,
    output logic [2:0] irq_priority
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    // mode from clock source and gate bits
    function automatic ctp_mode_type decode_mode(input logic cs,
                                                 input logic gate);
        ctp_mode_type m;
        m = CTP_MODE_TIMER;
        if (cs) begin
            m = CTP_MODE_COUNTER;
        end else if (gate) begin
            m = CTP_MODE_GATED;
        end
        return m;
    endfunction : decode_mode

    // one count event from the selected source
    function automatic logic src_event(input ctp_mode_type m,
                                       input logic rise,
                                       input logic gate);
        logic e;
        e = 1'b0;
        case (m)
            CTP_MODE_TIMER: e = 1'b1;
            CTP_MODE_GATED: e = gate;
            CTP_MODE_COUNTER: e = rise;
            default: e = 1'b0;
        endcase
        return e;
    endfunction : src_event

    // prescaler terminal count from the two select bits
    function automatic logic [7:0] ps_term(input logic [1:0] sel);
        logic [7:0] t;
        t = `CTP_PS_TERM_1;
        case (sel)
            2'b00: t = `CTP_PS_TERM_1;
            2'b01: t = `CTP_PS_TERM_8;
            2'b10: t = `CTP_PS_TERM_64;
            2'b11: t = `CTP_PS_TERM_256;
            default: t = `CTP_PS_TERM_1;
        endcase
        return t;
    endfunction : ps_term

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // bit order: ext lo, ext hi, gate lo, gate hi
    logic [3:0] sync1_q, sync1_d;
    logic [3:0] sync2_q, sync2_d;
    logic [3:0] sync3_q, sync3_d;
    logic [3:0] rise;

    // stage one is read only by stage two; edges come from two and three
    always_comb begin
        sync1_d = {gate_hi_pin, gate_lo_pin, ext_clk_hi_pin, ext_clk_lo_pin};
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        rise = sync2_q & ~sync3_q;
    end

    // synchroniser flops, frozen with the rest of the block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else if (clk_en) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
        end
    end

    // ------------------------------------------------------------------
    // core state: registers, prescalers, counts, flags
    // ------------------------------------------------------------------
    logic [15:0] ctrl_lo_q, ctrl_lo_d, ctrl_hi_q, ctrl_hi_d;
    logic [15:0] cnt_lo_q, cnt_lo_d, cnt_hi_q, cnt_hi_d;
    logic [15:0] per_lo_q, per_lo_d, per_hi_q, per_hi_d;
    logic [7:0] ps_lo_q, ps_lo_d, ps_hi_q, ps_hi_d;
    logic [1:0] stat_q, stat_d, mask_q, mask_d;
    logic [2:0] prio_lo_q, prio_lo_d, prio_hi_q, prio_hi_d;
    logic [2:0] irq_prio_q, irq_prio_d;
    logic [31:0] rdata_q, rdata_d;
    ctp_mode_type mode_lo, mode_hi;
    logic paired, run_lo, run_hi, ev_lo, ev_hi, tick_lo, tick_hi;
    logic match32, match_lo, match_hi;
    logic [1:0] set_flag, act;
    logic wr_en, rd_setup, addr_ok;
    logic wr_cnt_lo, wr_cnt_hi;
    logic [31:0] cnt32_inc;

    // transfers stall while the block is frozen
    assign pready = clk_en;
    assign prdata = rdata_q;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `CTP_ADDR_IRQ_PRIO);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && clk_en && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign wr_cnt_lo = wr_en && (paddr == `CTP_ADDR_CNT_LO);
    assign wr_cnt_hi = wr_en && (paddr == `CTP_ADDR_CNT_HI);
    // a zero priority disables its source; the lower one is dropped when paired
    assign act = stat_q & mask_q & {(prio_hi_q != 3'h0),
                                    (prio_lo_q != 3'h0) && !paired};
    assign irq = |act;
    assign irq_priority = irq_prio_q;

    always_comb begin
        ctrl_lo_d = ctrl_lo_q;
        ctrl_hi_d = ctrl_hi_q;
        cnt_lo_d = cnt_lo_q;
        cnt_hi_d = cnt_hi_q;
        per_lo_d = per_lo_q;
        per_hi_d = per_hi_q;
        ps_lo_d = ps_lo_q;
        ps_hi_d = ps_hi_q;
        mask_d = mask_q;
        prio_lo_d = prio_lo_q;
        prio_hi_d = prio_hi_q;
        rdata_d = rdata_q;
        set_flag = 2'b00;
        tick_lo = 1'b0;
        tick_hi = 1'b0;
        // only the lower control word carries the pair bit
        paired = ctrl_lo_q[`CTP_CTRL_PAIR];
        mode_lo = decode_mode(ctrl_lo_q[`CTP_CTRL_CS],
                              ctrl_lo_q[`CTP_CTRL_GATE]);
        mode_hi = decode_mode(ctrl_hi_q[`CTP_CTRL_CS],
                              ctrl_hi_q[`CTP_CTRL_GATE]);
        run_lo = ctrl_lo_q[`CTP_CTRL_RUN];
        run_hi = ctrl_hi_q[`CTP_CTRL_RUN] && !paired;
        ev_lo = src_event(mode_lo, rise[0], sync2_q[2]);
        ev_hi = src_event(mode_hi, rise[1], sync2_q[3]);
        match_lo = (cnt_lo_q == per_lo_q);
        match_hi = (cnt_hi_q == per_hi_q);
        match32 = ({cnt_hi_q, cnt_lo_q} == {per_hi_q, per_lo_q});
        cnt32_inc = {cnt_hi_q, cnt_lo_q} + 32'h0000_0001;

        // prescalers; the lower one also divides the paired count
        if (!run_lo) begin
            ps_lo_d = 8'h00;
        end else if (ev_lo) begin
            if (ps_lo_q >= ps_term(ctrl_lo_q[`CTP_CTRL_PS_MSB:
                                             `CTP_CTRL_PS_LSB])) begin
                ps_lo_d = 8'h00;
                tick_lo = 1'b1;
            end else begin
                ps_lo_d = ps_lo_q + 8'h01;
            end
        end
        if (!run_hi) begin
            ps_hi_d = 8'h00;
        end else if (ev_hi) begin
            if (ps_hi_q >= ps_term(ctrl_hi_q[`CTP_CTRL_PS_MSB:
                                             `CTP_CTRL_PS_LSB])) begin
                ps_hi_d = 8'h00;
                tick_hi = 1'b1;
            end else begin
                ps_hi_d = ps_hi_q + 8'h01;
            end
        end

        // counts: wrap to zero on the tick after a period match
        if (paired) begin
            if (tick_lo) begin
                if (match32) begin
                    cnt_lo_d = 16'h0000;
                    cnt_hi_d = 16'h0000;
                    set_flag[`CTP_IRQ_HI] = 1'b1;
                end else begin
                    cnt_lo_d = cnt32_inc[15:0];
                    cnt_hi_d = cnt32_inc[31:16];
                end
            end
        end else begin
            if (tick_lo) begin
                cnt_lo_d = match_lo ? 16'h0000 : cnt_lo_q + 16'h0001;
                set_flag[`CTP_IRQ_LO] = match_lo;
            end
            if (tick_hi) begin
                cnt_hi_d = match_hi ? 16'h0000 : cnt_hi_q + 16'h0001;
                set_flag[`CTP_IRQ_HI] = match_hi;
            end
        end

        // software writes win over counting in the same cycle
        stat_d = stat_q;
        if (wr_en) begin
            case (paddr)
                `CTP_ADDR_CTRL_LO: ctrl_lo_d = pwdata[15:0] & `CTP_CTRL_LO_MASK;
                `CTP_ADDR_CTRL_HI: ctrl_hi_d = pwdata[15:0] & `CTP_CTRL_HI_MASK;
                `CTP_ADDR_CNT_LO: cnt_lo_d = pwdata[15:0];
                `CTP_ADDR_CNT_HI: cnt_hi_d = pwdata[15:0];
                `CTP_ADDR_PER_LO: per_lo_d = pwdata[15:0];
                `CTP_ADDR_PER_HI: per_hi_d = pwdata[15:0];
                `CTP_ADDR_IRQ_STAT: stat_d = stat_q & ~pwdata[1:0];
                `CTP_ADDR_IRQ_MASK: mask_d = pwdata[1:0];
                `CTP_ADDR_IRQ_PRIO: begin
                    prio_lo_d = pwdata[`CTP_PRIO_LO_LSB +: 3];
                    prio_hi_d = pwdata[`CTP_PRIO_HI_LSB +: 3];
                end
                default: stat_d = stat_q;
            endcase
        end
        // a new event beats a clear in the same cycle
        stat_d = stat_d | set_flag;

        // read data captured in the setup phase
        if (rd_setup) begin
            case (paddr)
                `CTP_ADDR_CTRL_LO: rdata_d = {16'h0000, ctrl_lo_q};
                `CTP_ADDR_CTRL_HI: rdata_d = {16'h0000, ctrl_hi_q};
                `CTP_ADDR_CNT_LO: rdata_d = {16'h0000, cnt_lo_q};
                `CTP_ADDR_CNT_HI: rdata_d = {16'h0000, cnt_hi_q};
                `CTP_ADDR_PER_LO: rdata_d = {16'h0000, per_lo_q};
                `CTP_ADDR_PER_HI: rdata_d = {16'h0000, per_hi_q};
                `CTP_ADDR_IRQ_STAT: rdata_d = {30'h0000_0000, stat_q};
                `CTP_ADDR_IRQ_MASK: rdata_d = {30'h0000_0000, mask_q};
                `CTP_ADDR_IRQ_PRIO: rdata_d = {25'h000_0000, prio_hi_q,
                                               1'b0, prio_lo_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end

        // highest active priority, lagging irq by one cycle
        irq_prio_d = 3'h0;
        if (act[`CTP_IRQ_LO]) begin
            irq_prio_d = prio_lo_q;
        end
        if (act[`CTP_IRQ_HI] && (prio_hi_q > irq_prio_d)) begin
            irq_prio_d = prio_hi_q;
        end
    end

    // core flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_lo_q <= `CTP_CTRL_RST;
            ctrl_hi_q <= `CTP_CTRL_RST;
            cnt_lo_q <= 16'h0000;
            cnt_hi_q <= 16'h0000;
            per_lo_q <= `CTP_PER_RST;
            per_hi_q <= `CTP_PER_RST;
            ps_lo_q <= 8'h00;
            ps_hi_q <= 8'h00;
            stat_q <= 2'b00;
            mask_q <= 2'b00;
            prio_lo_q <= `CTP_PRIO_RST;
            prio_hi_q <= `CTP_PRIO_RST;
            irq_prio_q <= 3'h0;
            rdata_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ctrl_lo_q <= ctrl_lo_d;
            ctrl_hi_q <= ctrl_hi_d;
            cnt_lo_q <= cnt_lo_d;
            cnt_hi_q <= cnt_hi_d;
            per_lo_q <= per_lo_d;
            per_hi_q <= per_hi_d;
            ps_lo_q <= ps_lo_d;
            ps_hi_q <= ps_hi_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            prio_lo_q <= prio_lo_d;
            prio_hi_q <= prio_hi_d;
            irq_prio_q <= irq_prio_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    mode_decode_a: assert property (
        ctrl_lo_q[`CTP_CTRL_CS] |-> mode_lo == CTP_MODE_COUNTER)
        else $error("clock source bit did not select counter mode");
    timer_src_a: assert property (
        run_lo && mode_lo == CTP_MODE_TIMER |-> ev_lo)
        else $error("timer mode missed an instruction clock");
    ext_src_a: assert property (
        mode_lo == CTP_MODE_COUNTER && ev_lo |-> rise[0])
        else $error("counter advanced without a pin edge");
    gate_hold_a: assert property (
        mode_lo == CTP_MODE_GATED && !sync2_q[2] |-> !ev_lo)
        else $error("gated timer counted with gate low");
    upper_ignored_a: assert property (
        paired |-> !tick_hi)
        else $error("upper prescaler ran while paired");
    pair_flag_a: assert property (
        clk_en && paired && tick_lo && match32 && !wr_en |=>
        stat_q[`CTP_IRQ_HI] && $stable(stat_q[`CTP_IRQ_LO]))
        else $error("paired match did not set only the upper flag");
    wrap32_a: assert property (
        clk_en && paired && tick_lo && match32 && !wr_cnt_lo && !wr_cnt_hi
        |=> cnt_lo_q == 16'h0000 && cnt_hi_q == 16'h0000)
        else $error("paired count did not wrap at period");
    carry_a: assert property (
        clk_en && paired && tick_lo && !match32 && cnt_lo_q == 16'hFFFF
        && !wr_cnt_lo && !wr_cnt_hi
        |=> cnt_lo_q == 16'h0000 && cnt_hi_q == $past(cnt_hi_q) + 16'h0001)
        else $error("low word overflow did not carry to high word");
    presc_reload_a: assert property (
        clk_en && tick_lo |=> ps_lo_q == 8'h00)
        else $error("prescaler did not restart after a tick");
    sticky_set_a: assert property (
        clk_en && set_flag[`CTP_IRQ_LO] |=> stat_q[`CTP_IRQ_LO])
        else $error("event lost against a clear");

    wrap32_c: cover property (clk_en && paired && tick_lo && match32);
    gated_c: cover property (mode_lo == CTP_MODE_GATED && tick_lo);
    counter_c: cover property (mode_hi == CTP_MODE_COUNTER && tick_hi);
    irq_rise_c: cover property (!irq ##1 irq);

endmodule : ctp_timer_pair
`default_nettype wire
